// File: bacb_core.sv
// Functional notes
// - Equal-form compare-increment-branch subtracts source from destination unstored and branches on zero.
// - Both compare-increment-branch forms add one to the source pointer whether or not they branch.
// - Both compare-increment-branch forms leave every condition flag untouched.
// - Unequal-form compare-increment-branch branches on a nonzero difference and also bumps the pointer.
// - Decimal adjust turns the byte into two packed BCD digits using carry and half-carry.
// - After an add, decimal adjust adds 06, 60, 66 or nothing and sets carry when the high fix applies.
// - After a subtract, decimal adjust adds FA, A0, 9A or nothing and keeps carry.
// - Decimal adjust carry is set when the high-digit fix applies after an add, cleared otherwise, and kept as it was after a subtract.
// - Decimal adjust sets zero when the adjusted byte is zero.
// - Decimal adjust copies bit 7 of the adjusted byte into sign.
// - A compare with destination below source sets carry so an unsigned-not-below jump falls through.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module bacb_core
    import bacb_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire bacb_req_t req_in,
    input wire logic flags_wr_in,
    input wire bacb_flags_t flags_in,
    input wire logic [BACB_ADDR_W-1:0] addr_in,
    input wire logic [BACB_DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [BACB_DATA_W-1:0] rdata_out,
    output logic done_out,
    output logic [BACB_DATA_W-1:0] result_out,
    output logic result_we_out,
    output logic [BACB_DATA_W-1:0] ptr_out,
    output logic ptr_we_out,
    output logic pc_load_out,
    output logic [BACB_PC_W-1:0] pc_target_out,
    output bacb_flags_t flags_out
);
    bacb_state_t st_r;
    bacb_state_t st_nxt;
    logic [8:0] diff;
    logic diff_zero;
    logic [15:0] target;
    logic [7:0] da_value;
    logic da_carry;
    logic sw_flags_wr;

    // ---------------------------------------------------------------
    // Decimal adjust datapath
    // ---------------------------------------------------------------
    bacb_bcd_fix u_bcd_fix (
        .value_in(req_in.dst),
        .carry_in(st_r.flags.c),
        .half_in(st_r.flags.h),
        .subtract_in(st_r.flags.d),
        .adjusted_out(da_value),
        .carry_out(da_carry)
    );

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.result_we = 1'b0;
        st_nxt.ptr_we = 1'b0;
        st_nxt.pc_load = 1'b0;
        st_nxt.rdata = BACB_RDATA_IDLE;
        // Compare result is never stored, only inspected
        diff = {1'b0, req_in.dst} - {1'b0, req_in.src};
        diff_zero = (diff[7:0] == 8'h00);
        target = req_in.pc_next + {{8{req_in.disp[7]}}, req_in.disp};
        sw_flags_wr = wr_in && (addr_in == BACB_ADDR_FLAGS);

        // Software write first, core ALU load over it, own ops over both
        if (sw_flags_wr)
        begin
            st_nxt.flags = bacb_flags_t'(wdata_in);
            st_nxt.flags.rsvd = BACB_FLAGS_RSVD;
        end
        if (wr_in && (addr_in == BACB_ADDR_BRCOUNT))
        begin
            st_nxt.br_count = wdata_in;
        end
        if (flags_wr_in)
        begin
            st_nxt.flags = flags_in;
            st_nxt.flags.rsvd = BACB_FLAGS_RSVD;
        end

        if (start_in)
        begin
            st_nxt.done = 1'b1;
            case (req_in.op)
                BACB_OP_COMPARE:
                begin
                    st_nxt.flags.c = diff[8];
                    st_nxt.flags.z = diff_zero;
                    st_nxt.flags.s = diff[7];
                    st_nxt.flags.v = (req_in.dst[7] ^ req_in.src[7]) & (req_in.dst[7] ^ diff[7]);
                end
                BACB_OP_CIB_EQUAL, BACB_OP_CIB_UNEQUAL:
                begin
                    // Flags are rewritten with their old value, so any flag load this cycle is dropped
                    st_nxt.flags = st_r.flags;
                    st_nxt.ptr = req_in.ptr + BACB_PTR_STEP;
                    st_nxt.ptr_we = 1'b1;
                    if (req_in.op == BACB_OP_CIB_EQUAL)
                        st_nxt.taken = diff_zero;
                    else
                        st_nxt.taken = !diff_zero;
                    st_nxt.pc_load = st_nxt.taken;
                    st_nxt.pc_target = target;
                end
                BACB_OP_DECIMAL_ADJUST:
                begin
                    st_nxt.result = da_value;
                    st_nxt.result_we = 1'b1;
                    st_nxt.flags.c = da_carry;
                    st_nxt.flags.z = (da_value == 8'h00);
                    st_nxt.flags.s = da_value[7];
                end
                BACB_OP_JUMP_NOT_BELOW:
                begin
                    // Carry means the last compare saw a borrow
                    st_nxt.taken = !st_r.flags.c;
                    st_nxt.pc_load = !st_r.flags.c;
                    st_nxt.pc_target = target;
                end
                default:
                begin
                    st_nxt.done = 1'b0;
                end
            endcase
            if (st_nxt.pc_load)
            begin
                st_nxt.br_count = st_nxt.br_count + BACB_COUNT_STEP;
            end
        end

        // Register reads show state from before this cycle's updates
        if (rd_in)
        begin
            if (addr_in == BACB_ADDR_FLAGS)
                st_nxt.rdata = st_r.flags;
            else if (addr_in == BACB_ADDR_STATUS)
                st_nxt.rdata = {7'h00, st_r.taken};
            else if (addr_in == BACB_ADDR_BRCOUNT)
                st_nxt.rdata = st_r.br_count;
            else
                st_nxt.rdata = BACB_RDATA_IDLE;
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            st_r <= BACB_STATE_RST;
        else
            st_r <= st_nxt;
    end

    assign rdata_out = st_r.rdata;
    assign done_out = st_r.done;
    assign result_out = st_r.result;
    assign result_we_out = st_r.result_we;
    assign ptr_out = st_r.ptr;
    assign ptr_we_out = st_r.ptr_we;
    assign pc_load_out = st_r.pc_load;
    assign pc_target_out = st_r.pc_target;
    assign flags_out = st_r.flags;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    logic no_flag_writer;
    logic [3:0] dst_hi;
    logic [3:0] dst_lo;
    assign no_flag_writer = !flags_wr_in && !(wr_in && (addr_in == BACB_ADDR_FLAGS));
    assign dst_hi = req_in.dst[7:4];
    assign dst_lo = req_in.dst[3:0];

    sequence s_cib_any;
        start_in && ((req_in.op == BACB_OP_CIB_EQUAL) || (req_in.op == BACB_OP_CIB_UNEQUAL));
    endsequence

    sequence s_cmp_below;
        start_in && (req_in.op == BACB_OP_COMPARE) && (req_in.dst < req_in.src);
    endsequence

    sequence s_jump_clean;
        start_in && (req_in.op == BACB_OP_JUMP_NOT_BELOW) && no_flag_writer;
    endsequence

    sequence s_da_add;
        start_in && (req_in.op == BACB_OP_DECIMAL_ADJUST) && !st_r.flags.d;
    endsequence

    sequence s_da_sub;
        start_in && (req_in.op == BACB_OP_DECIMAL_ADJUST) && st_r.flags.d;
    endsequence

    a_cib_equal_taken: assert property (
        (start_in && (req_in.op == BACB_OP_CIB_EQUAL) && (req_in.dst == req_in.src))
        |=> pc_load_out && (pc_target_out == $past(req_in.pc_next) + {{8{$past(req_in.disp[7])}}, $past(req_in.disp)}))
        else $error("equal branch not taken to the right target");

    a_cib_equal_fall: assert property (
        (start_in && (req_in.op == BACB_OP_CIB_EQUAL) && (req_in.dst != req_in.src)) |=> !pc_load_out)
        else $error("equal branch taken on a mismatch");

    a_cib_unequal_taken: assert property (
        (start_in && (req_in.op == BACB_OP_CIB_UNEQUAL)) |=> (pc_load_out == ($past(req_in.dst) != $past(req_in.src))))
        else $error("unequal branch decision wrong");

    a_cib_ptr_step: assert property (
        s_cib_any |=> ptr_we_out && (ptr_out == $past(req_in.ptr) + BACB_PTR_STEP) ##1 !ptr_we_out || $past(start_in))
        else $error("source pointer not incremented once");

    a_cib_flags_kept: assert property (
        (s_cib_any and no_flag_writer) |=> $stable(flags_out))
        else $error("flags changed by compare-increment-branch");

    a_da_add_fix: assert property (
        (s_da_add and (!st_r.flags.c && !st_r.flags.h && (dst_hi <= BACB_BCD_HI_EDGE) && (dst_lo > BACB_BCD_MAX)))
        |=> (result_out == $past(req_in.dst) + BACB_FIX_ADD_LO) && !flags_out.c)
        else $error("low digit add correction wrong");

    a_da_add_high: assert property (
        (s_da_add and st_r.flags.c) |=> flags_out.c && (result_out[7:4] != $past(req_in.dst[7:4])))
        else $error("high digit add correction missing");

    a_da_sub_keep: assert property (
        s_da_sub |=> (flags_out.c == $past(st_r.flags.c))
        && ((result_out - $past(req_in.dst)) == ($past(st_r.flags.c) ? ($past(st_r.flags.h) ? BACB_FIX_SUB_BOTH : BACB_FIX_SUB_HI)
        : ($past(st_r.flags.h) ? BACB_FIX_SUB_LO : BACB_FIX_NONE))))
        else $error("subtract correction wrong");

    a_da_carry_out: assert property (
        (s_da_add and (!st_r.flags.c && (dst_hi <= BACB_BCD_MAX) && (dst_lo <= BACB_BCD_MAX) && !st_r.flags.h))
        |=> !flags_out.c && (result_out == $past(req_in.dst)))
        else $error("carry set without a high correction");

    a_da_zero_flag: assert property (
        (start_in && (req_in.op == BACB_OP_DECIMAL_ADJUST)) |=> result_we_out && (flags_out.z == (result_out == 8'h00)))
        else $error("zero flag does not match adjusted byte");

    a_da_sign_flag: assert property (
        (start_in && (req_in.op == BACB_OP_DECIMAL_ADJUST)) |=> (flags_out.s == result_out[7]))
        else $error("sign flag does not match bit 7");

    a_cmp_then_jump: assert property (
        s_cmp_below ##1 s_jump_clean |=> !pc_load_out && done_out)
        else $error("jump taken after a borrowing compare");

    a_cmp_sets_carry: assert property (
        s_cmp_below |=> flags_out.c [*1] ##0 done_out)
        else $error("borrow did not set carry");

    a_read_latency: assert property (
        (rd_in && (addr_in == BACB_ADDR_FLAGS)) |=> (rdata_out == $past(st_r.flags)) ##1 (rdata_out == 8'h00) || $past(rd_in))
        else $error("flags read data wrong or held too long");
endmodule
`default_nettype wire

// File: bacb_pkg.sv
`default_nettype none
package bacb_pkg;
    // ---------------------------------------------------------------
    // Widths and register map
    // ---------------------------------------------------------------
    localparam int BACB_DATA_W = 8;
    localparam int BACB_PC_W = 16;
    localparam int BACB_ADDR_W = 8;
    localparam logic [7:0] BACB_ADDR_FLAGS = 8'h00;
    localparam logic [7:0] BACB_ADDR_STATUS = 8'h04;
    localparam logic [7:0] BACB_ADDR_BRCOUNT = 8'h08;
    localparam logic [7:0] BACB_RDATA_IDLE = 8'h00;
    localparam logic [1:0] BACB_FLAGS_RSVD = 2'h0;

    // ---------------------------------------------------------------
    // Decimal adjust constants, pointer step and branch count step
    // ---------------------------------------------------------------
    localparam logic [3:0] BACB_BCD_MAX = 4'h9;
    localparam logic [3:0] BACB_BCD_HI_EDGE = 4'h8;
    localparam logic [7:0] BACB_FIX_NONE = 8'h00;
    localparam logic [7:0] BACB_FIX_ADD_LO = 8'h06;
    localparam logic [7:0] BACB_FIX_ADD_HI = 8'h60;
    localparam logic [7:0] BACB_FIX_ADD_BOTH = 8'h66;
    localparam logic [7:0] BACB_FIX_SUB_LO = 8'hfa;
    localparam logic [7:0] BACB_FIX_SUB_HI = 8'ha0;
    localparam logic [7:0] BACB_FIX_SUB_BOTH = 8'h9a;
    localparam logic [7:0] BACB_PTR_STEP = 8'h01;
    localparam logic [7:0] BACB_COUNT_STEP = 8'h01;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        BACB_OP_NONE,
        BACB_OP_COMPARE,
        BACB_OP_CIB_EQUAL,
        BACB_OP_CIB_UNEQUAL,
        BACB_OP_DECIMAL_ADJUST,
        BACB_OP_JUMP_NOT_BELOW
    } bacb_op_t;

    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
        logic d;
        logic h;
        logic [1:0] rsvd;
    } bacb_flags_t;

    typedef struct packed {
        bacb_op_t op;
        logic [7:0] dst;
        logic [7:0] src;
        logic [7:0] disp;
        logic [15:0] pc_next;
        logic [7:0] ptr;
    } bacb_req_t;

    typedef struct packed {
        bacb_flags_t flags;
        logic done;
        logic [7:0] result;
        logic result_we;
        logic [7:0] ptr;
        logic ptr_we;
        logic pc_load;
        logic [15:0] pc_target;
        logic taken;
        logic [7:0] br_count;
        logic [7:0] rdata;
    } bacb_state_t;

    localparam bacb_state_t BACB_STATE_RST = '0;
endpackage
`default_nettype wire

// File: bacb_bcd_fix.sv
`timescale 1ns/1ps
`default_nettype none
module bacb_bcd_fix
    import bacb_pkg::*;
(
    input wire logic [7:0] value_in,
    input wire logic carry_in,
    input wire logic half_in,
    input wire logic subtract_in,
    output logic [7:0] adjusted_out,
    output logic carry_out
);
    logic lo_fix;
    logic hi_fix;
    logic [7:0] corr;

    // ---------------------------------------------------------------
    // Correction selection
    // ---------------------------------------------------------------
    always_comb
    begin
        lo_fix = half_in || (value_in[3:0] > BACB_BCD_MAX);
        hi_fix = carry_in || (value_in[7:4] > BACB_BCD_MAX)
                 || ((value_in[7:4] > BACB_BCD_HI_EDGE) && (value_in[3:0] > BACB_BCD_MAX));
        if (subtract_in)
        begin
            // After a subtraction carry is kept as it was
            case ({carry_in, half_in})
                2'h1: corr = BACB_FIX_SUB_LO;
                2'h2: corr = BACB_FIX_SUB_HI;
                2'h3: corr = BACB_FIX_SUB_BOTH;
                default: corr = BACB_FIX_NONE;
            endcase
            carry_out = carry_in;
        end
        else
        begin
            if (lo_fix && hi_fix)
                corr = BACB_FIX_ADD_BOTH;
            else if (hi_fix)
                corr = BACB_FIX_ADD_HI;
            else if (lo_fix)
                corr = BACB_FIX_ADD_LO;
            else
                corr = BACB_FIX_NONE;
            carry_out = hi_fix;
        end
        adjusted_out = value_in + corr;
    end
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import bacb_pkg::*;
;
    // ---------------------------------------------------------------
    // Types and signals
    // ---------------------------------------------------------------
    typedef struct packed {
        bacb_op_t o;
        logic [7:0] d;
        logic [7:0] s;
        logic [7:0] dp;
        logic [7:0] p;
        logic ld;
        logic [15:0] tgt;
    } bacb_tb_cib_t;

    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic start_in = 1'b0;
    bacb_req_t req_in = '0;
    logic flags_wr_in = 1'b0;
    bacb_flags_t flags_in = '0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out;
    logic done_out;
    logic [7:0] result_out;
    logic result_we_out;
    logic [7:0] ptr_out;
    logic ptr_we_out;
    logic pc_load_out;
    logic [15:0] pc_target_out;
    bacb_flags_t flags_out;
    int fail_count = 0;
    int total_checks = 0;
    logic [7:0] exp_br = 8'h00;

    // Columns: byte before adjust, flags before, adjusted byte, carry after
    // Every row is a valid BCD add or subtract result
    logic [7:0] da_tab [11][4] = '{
        '{8'h3c, 8'h00, 8'h42, 8'h00}, '{8'h9a, 8'h00, 8'h00, 8'h01},
        '{8'ha5, 8'h10, 8'h05, 8'h01}, '{8'h12, 8'h04, 8'h18, 8'h00},
        '{8'h25, 8'h80, 8'h85, 8'h01}, '{8'h33, 8'h84, 8'h99, 8'h01},
        '{8'h8a, 8'h00, 8'h90, 8'h00}, '{8'h09, 8'h08, 8'h09, 8'h00},
        '{8'h0f, 8'h0c, 8'h09, 8'h00}, '{8'hf5, 8'h88, 8'h95, 8'h01},
        '{8'hff, 8'h8c, 8'h99, 8'h01}};

    // Displacements stay within the signed byte range
    bacb_tb_cib_t cib_tab [6] = '{
        '{BACB_OP_CIB_EQUAL, 8'h02, 8'h02, 8'h05, 8'h03, 1'b1, 16'h1005},
        '{BACB_OP_CIB_EQUAL, 8'h02, 8'h03, 8'h05, 8'hff, 1'b0, 16'h0000},
        '{BACB_OP_CIB_UNEQUAL, 8'h02, 8'h04, 8'h80, 8'h03, 1'b1, 16'h0f80},
        '{BACB_OP_CIB_UNEQUAL, 8'h07, 8'h07, 8'h7f, 8'h10, 1'b0, 16'h0000},
        '{BACB_OP_CIB_EQUAL, 8'h55, 8'h55, 8'h7f, 8'h20, 1'b1, 16'h107f},
        '{BACB_OP_CIB_UNEQUAL, 8'h00, 8'hff, 8'hfe, 8'h7f, 1'b1, 16'h0ffe}};

    always #50 mclk_in = ~mclk_in;

    bacb_core uut (
        .mclk_in(mclk_in), .rst_in(rst_in), .start_in(start_in), .req_in(req_in),
        .flags_wr_in(flags_wr_in), .flags_in(flags_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .done_out(done_out), .result_out(result_out), .result_we_out(result_we_out),
        .ptr_out(ptr_out), .ptr_we_out(ptr_we_out), .pc_load_out(pc_load_out),
        .pc_target_out(pc_target_out), .flags_out(flags_out)
    );

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic op(input bacb_op_t o, input logic [7:0] d, input logic [7:0] s,
                      input logic [7:0] dp, input logic [7:0] p, input logic [15:0] pcn);
        @(posedge mclk_in);
        start_in <= 1'b1;
        req_in <= '{o, d, s, dp, pcn, p};
        @(posedge mclk_in);
        start_in <= 1'b0;
        #1;
    endtask

    task automatic setf(input logic [7:0] f);
        @(posedge mclk_in);
        flags_wr_in <= 1'b1;
        flags_in <= bacb_flags_t'(f);
        @(posedge mclk_in);
        flags_wr_in <= 1'b0;
    endtask

    task automatic bw(input logic [7:0] a, input logic [7:0] dd);
        @(posedge mclk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= dd;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask

    task automatic br(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp, "read data");
        @(posedge mclk_in);
        #1;
        chk(rdata_out, 8'h00, "read data idle");
    endtask

    task automatic cj(input logic [7:0] d, input logic [7:0] s, input logic c);
        @(posedge mclk_in);
        start_in <= 1'b1;
        req_in <= '{BACB_OP_COMPARE, d, s, 8'h00, 16'h0000, 8'h00};
        @(posedge mclk_in);
        req_in <= '{BACB_OP_JUMP_NOT_BELOW, 8'h00, 8'h00, 8'h10, 16'h2000, 8'h00};
        @(posedge mclk_in);
        start_in <= 1'b0;
        #1;
        chk(flags_out.c, c, "compare borrow");
        chk(pc_load_out, !c, "not-below jump");
        if (!c)
        begin
            exp_br = 8'(exp_br + 8'h01);
            chk(pc_target_out, 16'h2010, "jump target");
        end
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial
    begin
        #200000;
        fail_count++;
        end_sim();
    end

    initial
    begin
        repeat (20) @(posedge mclk_in);
        rst_in <= 1'b0;
        #1;
        chk({done_out, result_we_out, ptr_we_out, pc_load_out}, 16'h0, "reset pulses");
        chk(flags_out, 8'h00, "reset flags");
        for (int i = 0; i < 11; i++)
        begin
            setf(da_tab[i][1]);
            op(BACB_OP_DECIMAL_ADJUST, da_tab[i][0], 8'h00, 8'h00, 8'h00, 16'h0000);
            chk({done_out, result_we_out}, 16'h3, "adjust strobes");
            chk(result_out, da_tab[i][2], "adjusted byte");
            chk(flags_out.c, da_tab[i][3][0], "adjust carry");
            chk(flags_out.z, da_tab[i][2] == 8'h00, "adjust zero");
            chk(flags_out.s, da_tab[i][2][7], "adjust sign");
            chk(flags_out[4:2], da_tab[i][1][4:2], "adjust keeps v d h");
        end
        setf(8'hfc);
        for (int i = 0; i < 6; i++)
        begin
            op(cib_tab[i].o, cib_tab[i].d, cib_tab[i].s, cib_tab[i].dp, cib_tab[i].p, 16'h1000);
            chk({done_out, ptr_we_out}, 16'h3, "pointer strobe");
            chk(ptr_out, 8'(cib_tab[i].p + 8'h01), "pointer step");
            chk(pc_load_out, cib_tab[i].ld, "branch decision");
            if (cib_tab[i].ld)
            begin
                exp_br = 8'(exp_br + 8'h01);
                chk(pc_target_out, cib_tab[i].tgt, "branch target");
            end
            chk(flags_out, 8'hfc, "branch keeps flags");
            @(posedge mclk_in);
            #1;
            chk({ptr_we_out, pc_load_out}, 16'h0, "pulse length");
            br(BACB_ADDR_STATUS, {7'h00, cib_tab[i].ld});
        end
        // A flag load in the same cycle as a branch must not land
        @(posedge mclk_in);
        flags_wr_in <= 1'b1;
        flags_in <= '0;
        start_in <= 1'b1;
        req_in <= '{BACB_OP_CIB_UNEQUAL, 8'h01, 8'h01, 8'h04, 16'h1000, 8'h40};
        @(posedge mclk_in);
        flags_wr_in <= 1'b0;
        start_in <= 1'b0;
        #1;
        chk(flags_out, 8'hfc, "branch beats flag load");
        chk(ptr_out, 8'h41, "pointer step no branch");
        cj(8'h05, 8'h0a, 1'b1);
        cj(8'h0a, 8'h05, 1'b0);
        op(BACB_OP_NONE, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000);
        chk(done_out, 1'b0, "no-op refused");
        br(BACB_ADDR_BRCOUNT, exp_br);
        bw(BACB_ADDR_FLAGS, 8'hff);
        br(BACB_ADDR_FLAGS, 8'hfc);
        bw(8'h14, 8'h00);
        br(8'h10, 8'h00);
        br(BACB_ADDR_FLAGS, 8'hfc);
        bw(BACB_ADDR_BRCOUNT, 8'h40);
        br(BACB_ADDR_BRCOUNT, 8'h40);
        @(posedge mclk_in);
        rst_in <= 1'b1;
        @(posedge mclk_in);
        rst_in <= 1'b0;
        #1;
        chk(flags_out, 8'h00, "second reset flags");
        br(BACB_ADDR_BRCOUNT, 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire
